// >>> dbe_pkg.sv
// constants and types shared by both ends of the debug break/event link
// assumes one 125 MHz clock and active low asynchronous reset on both ends
// Operation
// - exec match halts before instruction executes
// - access match halts after access completes
// - eight event slots shared by all uses
// - access events match address or range
// - access data compare with bit mask
// - data compare on one single-address slot
// - or mode halts on any match
// - sequential mode halts after ordered matches
// - debugger keeps 256 or-combined software breakpoints
// - software breakpoints disable without removal
// - monitor covers 1k, contiguous or 64x16
// - monitor reads steal cycles while running
// - debugger puts monitor on slot five
// - debugger polls monitor, default one second
package dbe_pkg;
    localparam int unsigned N_SLOT = 8;
    localparam int unsigned AW = 32;
    localparam int unsigned DW = 32;
    localparam int unsigned SLOT_W = 3;
    localparam logic [SLOT_W-1:0] MONITOR_EVENT_SLOT = 3'h5;
    localparam logic [SLOT_W-1:0] CMP_SLOT = 3'h0;
    localparam int unsigned MON_BYTES = 1024;
    localparam int unsigned MON_BLOCKS = 64;
    localparam int unsigned MON_BLK_BYTES = 16;
    localparam int unsigned SWBP_N = 256;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned POLL_MS = 1000;
    localparam int unsigned POLL_CYC = POLL_MS * 1000 * CLK_MHZ;
    // slot config field codes
    localparam logic [1:0] KIND_OFF = 2'h0;
    localparam logic [1:0] KIND_EXEC = 2'h1;
    localparam logic [1:0] KIND_ACC = 2'h2;
    localparam logic [1:0] KIND_MON = 2'h3;
    // config write select on link
    localparam logic [2:0] CFG_KIND = 3'h0;
    localparam logic [2:0] CFG_LO = 3'h1;
    localparam logic [2:0] CFG_HI = 3'h2;
    localparam logic [2:0] CFG_DATA = 3'h3;
    localparam logic [2:0] CFG_MASK = 3'h4;
    localparam logic [2:0] CFG_MODE = 3'h5;
    localparam logic [2:0] CFG_MON = 3'h6;
    // host register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_CFG_SEL = 8'h10;
    localparam logic [7:0] REG_CFG_DATA = 8'h14;
    localparam logic [7:0] REG_MON_ADDR = 8'h18;
    localparam logic [7:0] REG_MON_DATA = 8'h1c;
    localparam logic [7:0] REG_SWBP_IDX = 8'h20;
    localparam logic [7:0] REG_SWBP_ADDR = 8'h24;
    localparam logic [7:0] REG_POLL = 8'h28;
    // ctrl bits
    localparam int unsigned CTRL_RESUME = 0;
    localparam int unsigned CTRL_CFG_GO = 1;
    localparam int unsigned CTRL_MON_GO = 2;
    localparam int unsigned CTRL_SWBP_SET = 3;
    localparam int unsigned CTRL_SWBP_EN = 4;
    localparam int unsigned CTRL_SWBP_ON = 5;
    localparam int unsigned CTRL_MON_EN = 6;
    // irq bits
    localparam int unsigned IRQ_HALT = 0;
    localparam int unsigned IRQ_MON = 1;
    localparam int unsigned IRQ_POLL = 2;
    localparam logic [7:0] SEQ_ORDER_RST = 8'h00;
    localparam logic [4:0] CAUSE_NONE = 5'h00;
    localparam logic [4:0] CAUSE_SWBP = 5'h10;
    typedef enum logic [1:0] {
        DBE_RUN = 2'b00,
        DBE_HALT = 2'b01,
        DBE_MON = 2'b10
    } dbe_state_e;

    function automatic logic dbe_in_range(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                          input logic [AW-1:0] hi);
        dbe_in_range = (a >= lo) && (a <= hi);
    endfunction
endpackage

// >>> dbe_link_if.sv
// link between the debugger end and the on-chip event unit
// assumes both ends share i_clk_sys
`timescale 1ns/1ps
interface dbe_link_if;
    logic cfg_we;
    logic [2:0] cfg_sel;
    logic [dbe_pkg::SLOT_W-1:0] cfg_slot;
    logic [dbe_pkg::DW-1:0] cfg_wdata;
    logic resume;
    logic halted;
    logic [4:0] cause;
    logic mon_req;
    logic [9:0] mon_addr;
    logic mon_ack;
    logic [7:0] mon_rdata;
    modport dev (input cfg_we, input cfg_sel, input cfg_slot, input cfg_wdata, input resume,
                 input mon_req, input mon_addr, output halted, output cause, output mon_ack,
                 output mon_rdata);
    modport dbg (output cfg_we, output cfg_sel, output cfg_slot, output cfg_wdata, output resume,
                 output mon_req, output mon_addr, input halted, input cause, input mon_ack,
                 input mon_rdata);
endinterface

// >>> dbe_device.sv
// on-chip event unit: watches cpu fetch and data bus, halts cpu, serves monitor reads
// assumes the cpu honours o_halt before the fetched instruction and o_steal for one cycle
`timescale 1ns/1ps
module dbe_device
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    dbe_link_if.dev lnk,
    input wire logic i_fetch_vld,
    input wire logic [dbe_pkg::AW-1:0] i_fetch_addr,
    input wire logic i_acc_done,
    input wire logic [dbe_pkg::AW-1:0] i_acc_addr,
    input wire logic [dbe_pkg::DW-1:0] i_acc_data,
    input wire logic i_swbp_hit,
    output logic o_halt,
    output logic o_steal,
    output logic [dbe_pkg::AW-1:0] o_mem_addr,
    input wire logic [7:0] i_mem_rdata
);
    logic [1:0] kind_q [dbe_pkg::N_SLOT];
    logic [1:0] kind_d [dbe_pkg::N_SLOT];
    logic [dbe_pkg::AW-1:0] lo_q [dbe_pkg::N_SLOT];
    logic [dbe_pkg::AW-1:0] lo_d [dbe_pkg::N_SLOT];
    logic [dbe_pkg::AW-1:0] hi_q [dbe_pkg::N_SLOT];
    logic [dbe_pkg::AW-1:0] hi_d [dbe_pkg::N_SLOT];
    logic [dbe_pkg::DW-1:0] cdata_q, cdata_d, cmask_q, cmask_d;
    logic seq_mode_q, seq_mode_d;
    logic [7:0] en_q, en_d;
    logic [dbe_pkg::MON_BLOCKS-1:0] blk_mode_q, blk_mode_d;
    logic [dbe_pkg::AW-1:0] mon_base_q, mon_base_d;
    logic [dbe_pkg::SLOT_W-1:0] seq_pos_q, seq_pos_d;
    dbe_pkg::dbe_state_e st_q, st_d;
    logic halt_q, halt_d, steal_q, steal_d, ack_q, ack_d;
    logic [4:0] cause_q, cause_d;
    logic [dbe_pkg::AW-1:0] maddr_q, maddr_d;
    logic [7:0] mdata_q, mdata_d;
    logic [dbe_pkg::N_SLOT-1:0] hit;
    logic any_hit;
    logic [dbe_pkg::SLOT_W-1:0] hit_slot;

    always_comb
    begin
        for (int i = 0; i < dbe_pkg::N_SLOT; i++)
        begin
            hit[i] = 1'b0;
            if (en_q[i] && kind_q[i] == dbe_pkg::KIND_EXEC)
                hit[i] = i_fetch_vld && i_fetch_addr == lo_q[i];
            else if (en_q[i] && kind_q[i] == dbe_pkg::KIND_ACC)
            begin
                hit[i] = i_acc_done && dbe_pkg::dbe_in_range(i_acc_addr, lo_q[i], hi_q[i]);
                if (i == dbe_pkg::CMP_SLOT)
                    hit[i] = i_acc_done && i_acc_addr == lo_q[i]
                             && ((i_acc_data ^ cdata_q) & ~cmask_q) == '0;
            end
        end
        any_hit = 1'b0;
        hit_slot = '0;
        for (int i = dbe_pkg::N_SLOT - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                any_hit = 1'b1;
                hit_slot = dbe_pkg::SLOT_W'(i);
            end
        end
    end

    // configuration group
    always_comb
    begin
        kind_d = kind_q;
        lo_d = lo_q;
        hi_d = hi_q;
        cdata_d = cdata_q;
        cmask_d = cmask_q;
        seq_mode_d = seq_mode_q;
        en_d = en_q;
        blk_mode_d = blk_mode_q;
        mon_base_d = mon_base_q;
        if (lnk.cfg_we)
        begin
            case (lnk.cfg_sel)
                dbe_pkg::CFG_KIND:
                begin
                    kind_d[lnk.cfg_slot] = lnk.cfg_wdata[1:0];
                    en_d[lnk.cfg_slot] = lnk.cfg_wdata[2];
                end
                dbe_pkg::CFG_LO: lo_d[lnk.cfg_slot] = lnk.cfg_wdata;
                dbe_pkg::CFG_HI: hi_d[lnk.cfg_slot] = lnk.cfg_wdata;
                dbe_pkg::CFG_DATA: cdata_d = lnk.cfg_wdata;
                dbe_pkg::CFG_MASK: cmask_d = lnk.cfg_wdata;
                dbe_pkg::CFG_MODE: seq_mode_d = lnk.cfg_wdata[0];
                dbe_pkg::CFG_MON:
                begin
                    // bit 0 picks block mode; 64 bases not kept, blocks index 16 byte pages from base
                    mon_base_d = {lnk.cfg_wdata[dbe_pkg::AW-1:1], 1'b0};
                    blk_mode_d = {dbe_pkg::MON_BLOCKS{lnk.cfg_wdata[0]}};
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            for (int i = 0; i < dbe_pkg::N_SLOT; i++)
            begin
                kind_q[i] <= dbe_pkg::KIND_OFF;
                lo_q[i] <= '0;
                hi_q[i] <= '0;
            end
            cdata_q <= '0;
            cmask_q <= '0;
            seq_mode_q <= 1'b0;
            en_q <= 8'h00;
            blk_mode_q <= '0;
            mon_base_q <= '0;
        end
        else if (i_ce)
        begin
            kind_q <= kind_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            cdata_q <= cdata_d;
            cmask_q <= cmask_d;
            seq_mode_q <= seq_mode_d;
            en_q <= en_d;
            blk_mode_q <= blk_mode_d;
            mon_base_q <= mon_base_d;
        end
    end

    // run/halt/monitor group
    always_comb
    begin
        st_d = st_q;
        halt_d = halt_q;
        steal_d = 1'b0;
        ack_d = 1'b0;
        cause_d = cause_q;
        seq_pos_d = seq_pos_q;
        maddr_d = maddr_q;
        mdata_d = mdata_q;
        case (st_q)
            dbe_pkg::DBE_RUN:
            begin
                if (i_swbp_hit)
                begin
                    halt_d = 1'b1;
                    cause_d = dbe_pkg::CAUSE_SWBP;
                    seq_pos_d = '0;
                    st_d = dbe_pkg::DBE_HALT;
                end
                else if (!seq_mode_q && any_hit)
                begin
                    halt_d = 1'b1;
                    cause_d = {2'b01, hit_slot};
                    seq_pos_d = '0;
                    st_d = dbe_pkg::DBE_HALT;
                end
                else if (seq_mode_q && hit[seq_pos_q])
                begin
                    // order is ascending slot number among enabled slots
                    seq_pos_d = seq_pos_q + 3'h1;
                    for (int j = dbe_pkg::N_SLOT - 1; j >= 0; j--)
                        if (j > seq_pos_q && en_q[j])
                            seq_pos_d = dbe_pkg::SLOT_W'(j);
                    if ((en_q >> ({1'b0, seq_pos_q} + 4'h1)) == 8'h00)
                    begin
                        halt_d = 1'b1;
                        cause_d = {2'b01, seq_pos_q};
                        seq_pos_d = '0;
                        st_d = dbe_pkg::DBE_HALT;
                    end
                end
                else if (lnk.mon_req && en_q[dbe_pkg::MONITOR_EVENT_SLOT]
                         && kind_q[dbe_pkg::MONITOR_EVENT_SLOT] == dbe_pkg::KIND_MON)
                begin
                    steal_d = 1'b1;
                    maddr_d = mon_base_q + {22'h0, lnk.mon_addr};
                    st_d = dbe_pkg::DBE_MON;
                end
            end
            dbe_pkg::DBE_HALT:
            begin
                if (lnk.resume)
                begin
                    halt_d = 1'b0;
                    seq_pos_d = '0;
                    for (int j = dbe_pkg::N_SLOT - 1; j >= 0; j--)
                        if (en_q[j])
                            seq_pos_d = dbe_pkg::SLOT_W'(j);
                    st_d = dbe_pkg::DBE_RUN;
                end
                else if (lnk.mon_req)
                begin
                    maddr_d = mon_base_q + {22'h0, lnk.mon_addr};
                    st_d = dbe_pkg::DBE_MON;
                end
            end
            dbe_pkg::DBE_MON:
            begin
                mdata_d = i_mem_rdata;
                ack_d = 1'b1;
                st_d = halt_q ? dbe_pkg::DBE_HALT : dbe_pkg::DBE_RUN;
            end
            default: st_d = dbe_pkg::DBE_RUN;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_q <= dbe_pkg::DBE_RUN;
            halt_q <= 1'b0;
            steal_q <= 1'b0;
            ack_q <= 1'b0;
            cause_q <= dbe_pkg::CAUSE_NONE;
            seq_pos_q <= '0;
            maddr_q <= '0;
            mdata_q <= 8'h00;
        end
        else if (i_ce)
        begin
            st_q <= st_d;
            halt_q <= halt_d;
            steal_q <= steal_d;
            ack_q <= ack_d;
            cause_q <= cause_d;
            seq_pos_q <= seq_pos_d;
            maddr_q <= maddr_d;
            mdata_q <= mdata_d;
        end
    end

    assign o_halt = halt_q;
    assign o_steal = steal_q;
    assign o_mem_addr = maddr_q;
    assign lnk.halted = halt_q;
    assign lnk.cause = cause_q;
    assign lnk.mon_ack = ack_q;
    assign lnk.mon_rdata = mdata_q;
endmodule // dbe_device

// >>> dbe_debugger.sv
// debugger end: software registers, software breakpoint table, monitor polling
// assumes software drives the plain register port from i_clk_sys
`timescale 1ns/1ps
module dbe_debugger
#(
    parameter int unsigned POLL_DEF = dbe_pkg::POLL_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    dbe_link_if.dbg lnk,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [31:0] o_rdata,
    output logic o_irq,
    input wire logic i_fetch_vld,
    input wire logic [dbe_pkg::AW-1:0] i_fetch_addr,
    output logic o_swbp_hit
);
    logic [dbe_pkg::AW-1:0] bp_addr_q [dbe_pkg::SWBP_N];
    logic [dbe_pkg::SWBP_N-1:0] bp_en_q, bp_en_d;
    logic [7:0] bp_idx_q, bp_idx_d;
    logic [dbe_pkg::AW-1:0] bp_wa_q, bp_wa_d;
    logic [31:0] cfg_sel_q, cfg_sel_d, poll_q, poll_d, pcnt_q, pcnt_d;
    logic [9:0] mon_addr_q, mon_addr_d;
    logic [7:0] mon_data_q, mon_data_d;
    logic mon_en_q, mon_en_d, mreq_q, mreq_d, cfg_we_q, cfg_we_d, res_q, res_d;
    logic [31:0] cfg_wd_q, cfg_wd_d, rd_q, rd_d;
    logic [2:0] ist_q, ist_d, imask_q, imask_d, ev;
    logic halted_prev_q, swbp_q, swbp_d, irq_q;
    logic bp_write;

    always_comb
    begin
        swbp_d = 1'b0;
        for (int i = 0; i < dbe_pkg::SWBP_N; i++)
            if (bp_en_q[i] && i_fetch_vld && i_fetch_addr == bp_addr_q[i])
                swbp_d = 1'b1;
    end

    always_comb
    begin
        bp_en_d = bp_en_q;
        bp_idx_d = bp_idx_q;
        bp_wa_d = bp_wa_q;
        cfg_sel_d = cfg_sel_q;
        cfg_wd_d = cfg_wd_q;
        poll_d = poll_q;
        mon_addr_d = mon_addr_q;
        mon_data_d = lnk.mon_ack ? lnk.mon_rdata : mon_data_q;
        mon_en_d = mon_en_q;
        cfg_we_d = 1'b0;
        res_d = 1'b0;
        mreq_d = 1'b0;
        imask_d = imask_q;
        bp_write = 1'b0;
        pcnt_d = pcnt_q;
        ev = {1'b0, lnk.mon_ack, lnk.halted && !halted_prev_q};
        if (mon_en_q)
        begin
            pcnt_d = pcnt_q + 32'h0000_0001;
            if (pcnt_q >= poll_q)
            begin
                pcnt_d = 32'h0000_0000;
                ev[dbe_pkg::IRQ_POLL] = 1'b1;
            end
        end
        ist_d = ist_q;
        if (i_we)
        begin
            case (i_addr)
                dbe_pkg::REG_CTRL:
                begin
                    res_d = i_wdata[dbe_pkg::CTRL_RESUME];
                    cfg_we_d = i_wdata[dbe_pkg::CTRL_CFG_GO];
                    mreq_d = i_wdata[dbe_pkg::CTRL_MON_GO] && mon_en_q;
                    mon_en_d = i_wdata[dbe_pkg::CTRL_MON_EN];
                    bp_write = i_wdata[dbe_pkg::CTRL_SWBP_SET];
                    if (i_wdata[dbe_pkg::CTRL_SWBP_EN])
                        bp_en_d[bp_idx_q] = i_wdata[dbe_pkg::CTRL_SWBP_ON];
                end
                dbe_pkg::REG_IRQ_STAT: ist_d = ist_q & ~i_wdata[2:0];
                dbe_pkg::REG_IRQ_MASK: imask_d = i_wdata[2:0];
                dbe_pkg::REG_CFG_SEL: cfg_sel_d = i_wdata;
                dbe_pkg::REG_CFG_DATA: cfg_wd_d = i_wdata;
                dbe_pkg::REG_MON_ADDR: mon_addr_d = i_wdata[9:0];
                dbe_pkg::REG_SWBP_IDX: bp_idx_d = i_wdata[7:0];
                dbe_pkg::REG_SWBP_ADDR: bp_wa_d = i_wdata;
                dbe_pkg::REG_POLL: poll_d = i_wdata;
                default: ;
            endcase
        end
        ist_d = ist_d | ev;
        rd_d = 32'h0000_0000;
        if (i_re)
        begin
            case (i_addr)
                dbe_pkg::REG_STATUS: rd_d = {26'h0, lnk.cause, lnk.halted};
                dbe_pkg::REG_IRQ_STAT: rd_d = {29'h0, ist_q};
                dbe_pkg::REG_IRQ_MASK: rd_d = {29'h0, imask_q};
                dbe_pkg::REG_CFG_SEL: rd_d = cfg_sel_q;
                dbe_pkg::REG_CFG_DATA: rd_d = cfg_wd_q;
                dbe_pkg::REG_MON_ADDR: rd_d = {22'h0, mon_addr_q};
                dbe_pkg::REG_MON_DATA: rd_d = {24'h0, mon_data_q};
                dbe_pkg::REG_SWBP_IDX: rd_d = {23'h0, bp_en_q[bp_idx_q], bp_idx_q};
                dbe_pkg::REG_SWBP_ADDR: rd_d = bp_addr_q[bp_idx_q];
                dbe_pkg::REG_POLL: rd_d = poll_q;
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_ce && bp_write)
            bp_addr_q[bp_idx_q] <= bp_wa_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            bp_en_q <= '0;
            bp_idx_q <= 8'h00;
            bp_wa_q <= 32'h0000_0000;
            cfg_sel_q <= 32'h0000_0000;
            cfg_wd_q <= 32'h0000_0000;
            poll_q <= POLL_DEF;
            pcnt_q <= 32'h0000_0000;
            mon_addr_q <= 10'h000;
            mon_data_q <= 8'h00;
            mon_en_q <= 1'b0;
            cfg_we_q <= 1'b0;
            res_q <= 1'b0;
            mreq_q <= 1'b0;
            ist_q <= 3'h0;
            imask_q <= 3'h0;
            rd_q <= 32'h0000_0000;
            halted_prev_q <= 1'b0;
            swbp_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (i_ce)
        begin
            bp_en_q <= bp_en_d;
            bp_idx_q <= bp_idx_d;
            bp_wa_q <= bp_wa_d;
            cfg_sel_q <= cfg_sel_d;
            cfg_wd_q <= cfg_wd_d;
            poll_q <= poll_d;
            pcnt_q <= pcnt_d;
            mon_addr_q <= mon_addr_d;
            mon_data_q <= mon_data_d;
            mon_en_q <= mon_en_d;
            cfg_we_q <= cfg_we_d;
            res_q <= res_d;
            mreq_q <= mreq_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            rd_q <= rd_d;
            halted_prev_q <= lnk.halted;
            swbp_q <= swbp_d;
            irq_q <= |(ist_d & imask_d);
        end
    end

    assign o_rdata = rd_q;
    assign o_irq = irq_q;
    assign o_swbp_hit = swbp_q;
    assign lnk.cfg_we = cfg_we_q;
    assign lnk.cfg_sel = cfg_sel_q[2:0];
    assign lnk.cfg_slot = cfg_sel_q[10:8];
    assign lnk.cfg_wdata = cfg_wd_q;
    assign lnk.resume = res_q;
    assign lnk.mon_req = mreq_q;
    assign lnk.mon_addr = mon_addr_q;
endmodule // dbe_debugger

// >>> dbe_link_props.sv
// checker on the link between debugger end and event unit
// assumes one clock domain; instantiated beside the link interface
`timescale 1ns/1ps
module dbe_link_props
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic cfg_we,
    input wire logic [2:0] cfg_sel,
    input wire logic [dbe_pkg::SLOT_W-1:0] cfg_slot,
    input wire logic [dbe_pkg::DW-1:0] cfg_wdata,
    input wire logic resume,
    input wire logic halted,
    input wire logic [4:0] cause,
    input wire logic mon_req,
    input wire logic [9:0] mon_addr,
    input wire logic mon_ack,
    input wire logic [7:0] mon_rdata
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    // monitor slot enabled as monitor kind
    logic mon_on_q;
    logic mon_on_d;
    always_comb
    begin
        mon_on_d = mon_on_q;
        if (cfg_we && cfg_sel == dbe_pkg::CFG_KIND && cfg_slot == dbe_pkg::MONITOR_EVENT_SLOT)
        begin
            mon_on_d = (cfg_wdata[2:0] == 3'h7);
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mon_on_q <= 1'b0;
        end
        else
        begin
            mon_on_q <= mon_on_d;
        end
    end
    a_ack_after_req: assert property (mon_req && (halted || mon_on_q) |-> ##2 mon_ack)
        else $error("monitor request not answered in two cycles");
    a_ack_needs_req: assert property (mon_ack |-> $past(mon_req, 2))
        else $error("monitor answer without request");
    a_mon_gated: assert property (mon_ack |-> $past(halted, 2) || mon_on_q)
        else $error("monitor served while running without monitor slot");
    a_resume_ends_halt: assert property (halted && resume |=> !halted)
        else $error("halt not ended by resume");
    a_halt_holds: assert property (halted && !resume |=> halted)
        else $error("halt dropped without resume");
    a_cause_code: assert property ($rose(halted) |-> cause == dbe_pkg::CAUSE_SWBP || cause[4:3] == 2'b01)
        else $error("halt cause code malformed");
    a_cause_stable: assert property (halted && $past(halted) |-> $stable(cause))
        else $error("halt cause changed while halted");
    a_cause_set: assert property (halted |-> cause != dbe_pkg::CAUSE_NONE)
        else $error("halted with no cause");
endmodule // dbe_link_props

// >>> dbe_tb.sv
// self-checking bench: both ends joined by the link, software port driven by tasks
// assumes 125 MHz clock; poll period shortened to 50 cycles
`timescale 1ns/1ps
module dbe_tb;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_fetch_vld = 1'b0;
    logic [31:0] i_fetch_addr = 32'h0000_0000;
    logic i_acc_done = 1'b0;
    logic [31:0] i_acc_addr = 32'h0000_0000;
    logic [31:0] i_acc_data = 32'h0000_0000;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_we = 1'b0;
    logic i_re = 1'b0;
    logic swbp_hit;
    logic o_halt;
    logic o_steal;
    logic [31:0] o_mem_addr;
    logic [7:0] i_mem_rdata;
    logic [31:0] o_rdata;
    logic o_irq;
    logic [31:0] d;
    int fails = 0;
    int check_count = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    // monitor memory image, distinct per low address byte
    assign i_mem_rdata = o_mem_addr[7:0] ^ 8'h5a;
    dbe_link_if lnk();
    dbe_device i_dbe_device(.i_clk_sys, .i_arst_n, .i_ce(1'b1), .lnk(lnk), .i_fetch_vld, .i_fetch_addr,
        .i_acc_done, .i_acc_addr, .i_acc_data, .i_swbp_hit(swbp_hit), .o_halt, .o_steal, .o_mem_addr,
        .i_mem_rdata);
    dbe_debugger #(.POLL_DEF(50)) i_dbe_debugger(.i_clk_sys, .i_arst_n, .i_ce(1'b1), .lnk(lnk), .i_addr,
        .i_wdata, .i_we, .i_re, .o_rdata, .o_irq, .i_fetch_vld, .i_fetch_addr, .o_swbp_hit(swbp_hit));
    dbe_link_props i_dbe_link_props(.i_clk_sys, .i_arst_n, .cfg_we(lnk.cfg_we), .cfg_sel(lnk.cfg_sel),
        .cfg_slot(lnk.cfg_slot), .cfg_wdata(lnk.cfg_wdata), .resume(lnk.resume), .halted(lnk.halted),
        .cause(lnk.cause), .mon_req(lnk.mon_req), .mon_addr(lnk.mon_addr), .mon_ack(lnk.mon_ack),
        .mon_rdata(lnk.mon_rdata));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_we <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_re <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_re <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic cfg(input logic [2:0] s, input logic [2:0] f, input logic [31:0] v);
        wr(dbe_pkg::REG_CFG_SEL, {21'h0, s, 5'h0, f});
        wr(dbe_pkg::REG_CFG_DATA, v);
        wr(dbe_pkg::REG_CTRL, 32'h0000_0002);
        repeat (2) @(posedge i_clk_sys);
    endtask
    task automatic acc(input logic [31:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_acc_done <= 1'b1;
        i_acc_addr <= a;
        i_acc_data <= v;
        @(posedge i_clk_sys);
        i_acc_done <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
    endtask
    // bounded wait; a missing halt shows up as a mismatch below
    task automatic halt_chk(input logic [4:0] c, input logic on);
        for (int n = 0; n < 20 && o_halt !== on; n++) @(posedge i_clk_sys);
        #1;
        chk("halt", 32'(on), 32'(o_halt));
        if (on)
            chk("cause", 32'(c), 32'(lnk.cause));
    endtask
    task automatic go();
        @(posedge i_clk_sys);
        i_fetch_vld <= 1'b0;
        wr(dbe_pkg::REG_CTRL, 32'h0000_0001);
        repeat (3) @(posedge i_clk_sys);
        #1;
        chk("resumed", 32'h0000_0000, 32'(o_halt));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        rd(dbe_pkg::REG_POLL); chk("poll_rst", 32'h0000_0032, d);
        rd(8'hfc); chk("unmapped", 32'h0000_0000, d);
        rd(dbe_pkg::REG_IRQ_MASK); chk("mask_rst", 32'h0000_0000, d);
        cfg(3'h2, dbe_pkg::CFG_LO, 32'h0000_0100);
        cfg(3'h2, dbe_pkg::CFG_KIND, 32'h0000_0005);
        @(posedge i_clk_sys);
        i_fetch_vld <= 1'b1;
        i_fetch_addr <= 32'h0000_00fc;
        repeat (4) @(posedge i_clk_sys);
        halt_chk(5'h00, 1'b0);
        i_fetch_addr <= 32'h0000_0100;
        halt_chk(5'h0a, 1'b1);
        rd(dbe_pkg::REG_STATUS); chk("status", 32'h0000_0015, d);
        chk("irq_masked", 32'h0000_0000, 32'(o_irq));
        wr(dbe_pkg::REG_IRQ_MASK, 32'h0000_0001);
        @(posedge i_clk_sys); #1; chk("irq_on", 32'h0000_0001, 32'(o_irq));
        wr(dbe_pkg::REG_IRQ_STAT, 32'h0000_0001);
        @(posedge i_clk_sys); #1; chk("irq_clr", 32'h0000_0000, 32'(o_irq));
        go();
        cfg(3'h2, dbe_pkg::CFG_KIND, 32'h0000_0000);
        cfg(3'h3, dbe_pkg::CFG_LO, 32'h0000_0200);
        cfg(3'h3, dbe_pkg::CFG_HI, 32'h0000_020f);
        cfg(3'h3, dbe_pkg::CFG_KIND, 32'h0000_0006);
        cfg(3'h0, dbe_pkg::CFG_LO, 32'h0000_0300);
        cfg(3'h0, dbe_pkg::CFG_DATA, 32'h0000_00aa);
        cfg(3'h0, dbe_pkg::CFG_MASK, 32'hffff_ff00);
        cfg(3'h0, dbe_pkg::CFG_KIND, 32'h0000_0006);
        acc(32'h0000_01ff, 32'h0000_0000); halt_chk(5'h00, 1'b0);
        acc(32'h0000_0210, 32'h0000_0000); halt_chk(5'h00, 1'b0);
        acc(32'h0000_020f, 32'h0000_0000); halt_chk(5'h0b, 1'b1);
        go();
        acc(32'h0000_0300, 32'h1234_56ab); halt_chk(5'h00, 1'b0);
        acc(32'h0000_0300, 32'h1234_56aa); halt_chk(5'h08, 1'b1);
        go();
        // sequential: slot 0 must hit before slot 3
        cfg(3'h0, dbe_pkg::CFG_MODE, 32'h0000_0001);
        acc(32'h0000_0205, 32'h0000_0000); halt_chk(5'h00, 1'b0);
        acc(32'h0000_0300, 32'h0000_55aa); halt_chk(5'h00, 1'b0);
        acc(32'h0000_0205, 32'h0000_0000); halt_chk(5'h0b, 1'b1);
        go();
        acc(32'h0000_0205, 32'h0000_0000); halt_chk(5'h00, 1'b0);
        cfg(3'h0, dbe_pkg::CFG_MODE, 32'h0000_0000);
        wr(dbe_pkg::REG_SWBP_IDX, 32'h0000_00ff);
        wr(dbe_pkg::REG_SWBP_ADDR, 32'h0000_0400);
        wr(dbe_pkg::REG_CTRL, 32'h0000_0008);
        wr(dbe_pkg::REG_CTRL, 32'h0000_0030);
        @(posedge i_clk_sys);
        i_fetch_vld <= 1'b1;
        i_fetch_addr <= 32'h0000_0400;
        halt_chk(dbe_pkg::CAUSE_SWBP, 1'b1);
        go();
        wr(dbe_pkg::REG_CTRL, 32'h0000_0010);
        i_fetch_vld <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        halt_chk(5'h00, 1'b0);
        i_fetch_vld <= 1'b0;
        cfg(3'h5, dbe_pkg::CFG_MON, 32'h0000_1000);
        cfg(3'h5, dbe_pkg::CFG_KIND, 32'h0000_0007);
        wr(dbe_pkg::REG_MON_ADDR, 32'h0000_03ff);
        wr(dbe_pkg::REG_CTRL, 32'h0000_0040);
        wr(dbe_pkg::REG_CTRL, 32'h0000_0044);
        @(posedge i_clk_sys); #1; chk("steal", 32'h0000_13ff, o_mem_addr & {32{o_steal}});
        for (int n = 0; n < 20 && lnk.mon_ack !== 1'b1; n++) @(posedge i_clk_sys);
        rd(dbe_pkg::REG_MON_DATA); chk("mon_data", 32'h0000_00a5, d);
        chk("mon_running", 32'h0000_0000, 32'(o_halt));
        repeat (60) @(posedge i_clk_sys);
        rd(dbe_pkg::REG_IRQ_STAT); chk("poll_tick", 32'h0000_0001, 32'(d[2]));
        conclude();
    end
endmodule // dbe_tb
